// ---- rtl/lhc_pkg.sv ----
package lhc_pkg;

    // ****************************************
    // Bus nibble encodings
    // ****************************************
    localparam logic [3:0] START_NIB      = 4'h0;
    localparam logic [3:0] CT_IO_RD       = 4'h0;
    localparam logic [3:0] CT_IO_WR       = 4'h2;
    localparam logic [3:0] CT_DMA_RD      = 4'h8;
    localparam logic [3:0] CT_DMA_WR      = 4'hA;
    localparam logic [3:0] TAR_NIB        = 4'hF;
    localparam logic [3:0] SYNC_READY     = 4'h0;
    localparam logic [3:0] SYNC_SHORT     = 4'h5;
    localparam logic [3:0] SYNC_LONG      = 4'h6;
    localparam logic [3:0] SYNC_READY_ALT = 4'h9;
    localparam logic [3:0] SYNC_ERROR     = 4'hA;
    localparam logic [3:0] SIZE_BYTE      = 4'h0;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ          = 50;
    localparam int PD_LEAD_US       = 30;
    localparam int PD_LEAD_CYC      = PD_LEAD_US * CLK_MHZ;
    localparam int RST_CLK_US       = 100;
    localparam int RST_CLK_CYC      = RST_CLK_US * CLK_MHZ;
    localparam int SYNC_INVALID_MAX = 3;
    localparam int SHORT_SYNC_MAX   = 8;
    localparam int LONG_SYNC_MAX    = 330;
    localparam int BUS_DIV          = 2;

    // ****************************************
    // Request and answer carriers
    // ****************************************
    typedef enum logic [1:0] {
        LHC_IO_RD  = 2'b00,
        LHC_IO_WR  = 2'b01,
        LHC_DMA_RD = 2'b10,
        LHC_DMA_WR = 2'b11
    } lhc_kind_t;

    typedef struct packed {
        lhc_kind_t   kind;
        logic [15:0] addr;
        logic [2:0]  chan;
        logic [7:0]  data;
    } lhc_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic       error;
        logic       timeout;
    } lhc_rsp_t;

endpackage

// ---- rtl/lhc_sync2.sv ----
`timescale 1ns/10ps
`default_nettype none
module lhc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta;

    // Two stages for pin inputs; meta feeds only q_o
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= '1;
            q_o  <= '1;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/lhc_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module lhc_host #(
    parameter int PD_LEAD_CYC = lhc_pkg::PD_LEAD_CYC,
    parameter int RST_CLK_CYC = lhc_pkg::RST_CLK_CYC
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire logic             req_valid_i,
    input  wire lhc_pkg::lhc_req_t req_i,
    output logic                  req_ready_o,
    output logic                  rsp_valid_o,
    output lhc_pkg::lhc_rsp_t     rsp_o,
    input  wire logic             sleep_i,
    output logic                  sleep_ready_o,
    output logic                  dma_req_o,
    output logic                  lclk_o,
    output logic                  lreset_n_o,
    output logic                  lframe_n_o,
    output logic                  lpcpd_n_o,
    output logic [3:0]            lad_o,
    output logic                  lad_oe_o,
    input  wire logic [3:0]       lad_i,
    input  wire logic             ldrq_n_i
);
    // ****************************************
    // Bus clock divider and pin synchronisers
    // ****************************************
    logic       div_cnt;
    logic       tick;
    logic [3:0] lad_s;
    logic       ldrq_s;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt <= 1'b0;
            lclk_o  <= 1'b0;
        end else begin
            div_cnt <= ~div_cnt;
            lclk_o  <= ~div_cnt;
        end
    end
    // Host acts on the bus clock falling edge
    assign tick = div_cnt;

    lhc_sync2 #(.W(5)) u_sync (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .d_i    ({lad_i, ldrq_n_i}),
        .q_o    ({lad_s, ldrq_s})
    );

    // ****************************************
    // Bus reset and powerdown sequencing
    // ****************************************
    logic [31:0] rst_cnt;
    logic [31:0] pd_cnt;
    logic        bus_up;
    logic        bus_idle;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rst_cnt    <= '0;
            lreset_n_o <= 1'b0;
        end else if (rst_cnt < 32'(RST_CLK_CYC)) begin
            rst_cnt <= rst_cnt + 32'd1;
        end else begin
            lreset_n_o <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            lpcpd_n_o     <= 1'b1;
            pd_cnt        <= '0;
            sleep_ready_o <= 1'b0;
        end else if (sleep_i && !bus_idle && lpcpd_n_o) begin
            // Let a running cycle finish before cutting the bus
            lpcpd_n_o <= 1'b1;
        end else if (sleep_i) begin
            lpcpd_n_o <= 1'b0;
            if (pd_cnt < 32'(PD_LEAD_CYC)) begin
                pd_cnt <= pd_cnt + 32'd1;
            end else begin
                sleep_ready_o <= 1'b1;
            end
        end else begin
            lpcpd_n_o     <= 1'b1;
            pd_cnt        <= '0;
            sleep_ready_o <= 1'b0;
        end
    end

    assign bus_up = lreset_n_o && lpcpd_n_o;
    // Request ignored in reset and powerdown
    assign dma_req_o = bus_up && !ldrq_s;

    // ****************************************
    // Cycle engine
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_START = 4'h1,
        ST_CT    = 4'h2,
        ST_FLD   = 4'h3,
        ST_TAR1  = 4'h4,
        ST_TAR2  = 4'h5,
        ST_SYNC  = 4'h6,
        ST_RDATA = 4'h7,
        ST_TARB1 = 4'h8,
        ST_TARB2 = 4'h9,
        ST_ABORT = 4'hA
    } lhc_state_t;

    lhc_state_t        state;
    lhc_pkg::lhc_req_t cur;
    logic [3:0]        fld_idx;
    logic [3:0]        fld_len;
    logic [8:0]        wait_cnt;
    logic [1:0]        bad_cnt;
    logic [3:0]        wait_code;
    logic              is_rd;
    logic              is_dma;

    assign is_rd  = (cur.kind == lhc_pkg::LHC_IO_RD) || (cur.kind == lhc_pkg::LHC_DMA_WR);
    assign is_dma = cur.kind[1];
    assign bus_idle = (state == ST_IDLE);
    assign req_ready_o = bus_up && !sleep_i && (state == ST_IDLE);

    // Nibble sent after the cycle type, per kind
    function automatic logic [3:0] out_nib(input lhc_pkg::lhc_req_t r, input logic [3:0] i);
        logic wr;
        wr = (r.kind == lhc_pkg::LHC_IO_WR) || (r.kind == lhc_pkg::LHC_DMA_RD);
        if (!r.kind[1]) begin
            if (i < 4'd4) begin
                out_nib = r.addr[4'(15 - 4 * i) -: 4];
            end else begin
                out_nib = (i == 4'd4) ? r.data[3:0] : r.data[7:4];
            end
        end else begin
            if (i == 4'd0) begin
                out_nib = {1'b0, r.chan};
            end else if (i == 4'd1) begin
                out_nib = lhc_pkg::SIZE_BYTE;
            end else begin
                out_nib = (i == 4'd2) ? r.data[3:0] : r.data[7:4];
            end
        end
        if (!wr && i > (r.kind[1] ? 4'd1 : 4'd3)) begin
            out_nib = lhc_pkg::TAR_NIB;
        end
    endfunction

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state       <= ST_IDLE;
            cur         <= '0;
            fld_idx     <= '0;
            fld_len     <= '0;
            wait_cnt    <= '0;
            bad_cnt     <= '0;
            wait_code   <= '0;
            lframe_n_o  <= 1'b1;
            lad_o       <= 4'hF;
            lad_oe_o    <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_o       <= '0;
        end else if (!bus_up) begin
            state      <= ST_IDLE;
            lframe_n_o <= 1'b1;
            lad_oe_o   <= 1'b0;
            rsp_valid_o <= 1'b0;
        end else begin
            rsp_valid_o <= 1'b0;
            if (tick) begin
                unique case (state)
                    ST_IDLE: begin
                        lad_oe_o <= 1'b0;
                        if (req_valid_i && !sleep_i) begin
                            cur        <= req_i;
                            lframe_n_o <= 1'b0;
                            lad_o      <= lhc_pkg::START_NIB;
                            lad_oe_o   <= 1'b1;
                            state      <= ST_START;
                        end
                    end
                    ST_START: begin
                        lframe_n_o <= 1'b1;
                        unique case (cur.kind)
                            lhc_pkg::LHC_IO_RD:  lad_o <= lhc_pkg::CT_IO_RD;
                            lhc_pkg::LHC_IO_WR:  lad_o <= lhc_pkg::CT_IO_WR;
                            lhc_pkg::LHC_DMA_RD: lad_o <= lhc_pkg::CT_DMA_RD;
                            lhc_pkg::LHC_DMA_WR: lad_o <= lhc_pkg::CT_DMA_WR;
                        endcase
                        fld_idx <= '0;
                        fld_len <= is_dma ? (is_rd ? 4'd2 : 4'd4) : (is_rd ? 4'd4 : 4'd6);
                        state   <= ST_CT;
                    end
                    ST_CT, ST_FLD: begin
                        if (fld_idx == fld_len) begin
                            lad_o <= lhc_pkg::TAR_NIB;
                            state <= ST_TAR1;
                        end else begin
                            lad_o   <= out_nib(cur, fld_idx);
                            fld_idx <= fld_idx + 4'd1;
                            state   <= ST_FLD;
                        end
                    end
                    ST_TAR1: begin
                        lad_oe_o  <= 1'b0;
                        wait_cnt  <= '0;
                        bad_cnt   <= '0;
                        wait_code <= '0;
                        state     <= ST_SYNC;
                    end
                    ST_TAR2: state <= ST_SYNC;
                    ST_SYNC: begin
                        unique case (lad_s)
                            lhc_pkg::SYNC_READY, lhc_pkg::SYNC_READY_ALT,
                            lhc_pkg::SYNC_ERROR: begin
                                rsp_o.error   <= (lad_s == lhc_pkg::SYNC_ERROR);
                                rsp_o.timeout <= 1'b0;
                                fld_idx       <= '0;
                                state         <= is_rd ? ST_RDATA : ST_TARB1;
                            end
                            lhc_pkg::SYNC_SHORT, lhc_pkg::SYNC_LONG: begin
                                bad_cnt   <= '0;
                                wait_cnt  <= wait_cnt + 9'd1;
                                wait_code <= lad_s;
                                // Switching codes or an overlong run breaks the cycle
                                if ((wait_code != 4'h0 && wait_code != lad_s) ||
                                    (lad_s == lhc_pkg::SYNC_SHORT &&
                                     wait_cnt >= 9'(lhc_pkg::SHORT_SYNC_MAX)) ||
                                    (wait_cnt >= 9'(lhc_pkg::LONG_SYNC_MAX))) begin
                                    state <= ST_ABORT;
                                end
                            end
                            default: begin
                                bad_cnt <= bad_cnt + 2'd1;
                                if (bad_cnt == 2'(lhc_pkg::SYNC_INVALID_MAX - 1)) begin
                                    state <= ST_ABORT;
                                end
                            end
                        endcase
                    end
                    ST_RDATA: begin
                        // Data follows sync even after an error
                        if (fld_idx == 4'd0) begin
                            rsp_o.data[3:0] <= lad_s;
                            fld_idx         <= 4'd1;
                        end else begin
                            rsp_o.data[7:4] <= lad_s;
                            state           <= ST_TARB1;
                        end
                    end
                    ST_TARB1: state <= ST_TARB2;
                    ST_TARB2: begin
                        // One byte per cycle, so an error simply ends it
                        rsp_valid_o <= 1'b1;
                        state       <= ST_IDLE;
                    end
                    ST_ABORT: begin
                        // Abort: frame low with LAD at 4'hF for one tick, then back to idle
                        lframe_n_o    <= 1'b0;
                        lad_o         <= 4'hF;
                        lad_oe_o      <= 1'b1;
                        rsp_o.timeout <= 1'b1;
                        rsp_o.error   <= 1'b1;
                        rsp_valid_o   <= 1'b1;
                        state         <= ST_IDLE;
                        lframe_n_o    <= 1'b0;
                    end
                    default: state <= ST_IDLE;
                endcase
                if (state == ST_IDLE && lframe_n_o == 1'b0 && !(req_valid_i && !sleep_i)) begin
                    lframe_n_o <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/lhc_host_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module lhc_host_mon #(
    parameter int PD_LEAD_CYC = 10,
    parameter int RST_CLK_CYC = 20
) (
    input wire logic       mclk_i,
    input wire logic       rst_i,
    input wire logic       req_ready_o,
    input wire logic       rsp_valid_o,
    input wire logic       sleep_i,
    input wire logic       sleep_ready_o,
    input wire logic       dma_req_o,
    input wire logic       lreset_n_o,
    input wire logic       lframe_n_o,
    input wire logic       lpcpd_n_o,
    input wire logic [3:0] lad_o,
    input wire logic       lad_oe_o,
    input wire logic       ldrq_n_i
);
    int pd_cnt;
    int run_cnt;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // Saturating, so a long sleep cannot wrap
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) pd_cnt <= 0;
        else if (lpcpd_n_o) pd_cnt <= 0;
        else if (pd_cnt < PD_LEAD_CYC) pd_cnt <= pd_cnt + 1;
    end
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) run_cnt <= 0;
        else if (run_cnt < RST_CLK_CYC) run_cnt <= run_cnt + 1;
    end

    // ****
    // Checks
    // ****
    sequence s_start;
        !lframe_n_o && lad_oe_o && lad_o == lhc_pkg::START_NIB;
    endsequence
    sequence s_drq_low;
        (!ldrq_n_i && lreset_n_o && lpcpd_n_o) [*3];
    endsequence

    a_reset_quiet: assert property (
        !lreset_n_o |-> lframe_n_o && !lad_oe_o && !dma_req_o) else $error("bus active in reset");
    a_cycle_type: assert property (
        s_start ##1 lframe_n_o |-> lad_oe_o && !lad_o[0] && !lad_o[2]) else $error("bad cycle type");
    a_dma_follows: assert property (
        s_drq_low |-> dma_req_o) else $error("dma request lost");
    a_pd_no_dma: assert property (
        !lpcpd_n_o |-> !dma_req_o) else $error("dma request in powerdown");
    a_sleep_blocks: assert property (
        sleep_i |-> !req_ready_o) else $error("request taken while sleeping");
    a_pd_lead: assert property (
        sleep_ready_o |-> !lpcpd_n_o && pd_cnt >= PD_LEAD_CYC - 2) else $error("powerdown lead short");
    a_rst_wait: assert property (
        $rose(lreset_n_o) |-> run_cnt >= RST_CLK_CYC - 2) else $error("bus reset released early");
    a_no_lrst_drop: assert property (
        !$fell(lreset_n_o)) else $error("bus reset pulsed");
    a_rsp_pulse: assert property (
        rsp_valid_o |=> !rsp_valid_o) else $error("answer longer than one cycle");
endmodule

bind lhc_host lhc_host_mon #(.PD_LEAD_CYC(PD_LEAD_CYC), .RST_CLK_CYC(RST_CLK_CYC)) u_mon (
    .mclk_i(mclk_i), .rst_i(rst_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .sleep_i(sleep_i), .sleep_ready_o(sleep_ready_o), .dma_req_o(dma_req_o),
    .lreset_n_o(lreset_n_o), .lframe_n_o(lframe_n_o), .lpcpd_n_o(lpcpd_n_o),
    .lad_o(lad_o), .lad_oe_o(lad_oe_o), .ldrq_n_i(ldrq_n_i));
`default_nettype wire

// ---- testbench/lhc_dev_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module lhc_dev_model #(
    parameter logic [15:0] BASE = 16'h03E8
) (
    input  wire logic       mclk_i,
    input  wire logic       lclk_i,
    input  wire logic       lreset_n_i,
    input  wire logic       lframe_n_i,
    input  wire logic       lpcpd_n_i,
    input  wire logic [3:0] lad_i,
    input  wire logic       dma_want_i,
    input  wire logic       err_i,
    output logic      [3:0] lad_o,
    output logic            lad_oe_o,
    output logic            ldrq_n_o
);
    logic [3:0]  nib [8];
    logic [7:0]  mem [8];
    logic [3:0]  ct, fr_lad, waits, last, cnt;
    logic [1:0]  st;
    logic        fr_n, io, rd;
    logic [15:0] addr;
    logic [7:0]  rbyte;

    // ****
    // Target side
    // ****
    // Pins taken just before each edge, as a real input stage would
    always @(negedge mclk_i) begin
        fr_n <= lframe_n_i;
        fr_lad <= lad_i;
    end
    assign io = !ct[3];
    assign rd = (ct == lhc_pkg::CT_IO_RD) || (ct == lhc_pkg::CT_DMA_WR);
    assign last = io ? (rd ? 4'd5 : 4'd7) : (rd ? 4'd3 : 4'd5);
    assign waits = io ? (rd ? 4'd3 : 4'd2) : (rd ? 4'd4 : 4'd3);
    assign addr = {nib[0], nib[1], nib[2], nib[3]};
    assign rbyte = io ? mem[addr[2:0]] : mem[nib[0][2:0]];
    assign ldrq_n_o = !lpcpd_n_i ? 1'b0 : (!lreset_n_i || !dma_want_i);

    always @(posedge lclk_i or negedge lreset_n_i) begin
        if (!lreset_n_i || !lpcpd_n_i) begin
            st <= 2'd0;
            lad_oe_o <= 1'b0;
        end else if (!fr_n) begin
            lad_oe_o <= 1'b0;
            st <= (fr_lad == lhc_pkg::START_NIB) ? 2'd1 : 2'd0;
        end else if (st == 2'd1) begin
            ct <= fr_lad;
            cnt <= 4'd0;
            st <= (!fr_lad[0] && !fr_lad[2]) ? 2'd2 : 2'd0;
        end else if (st == 2'd2) begin
            nib[cnt[2:0]] <= fr_lad;
            cnt <= (cnt == last) ? 4'd0 : cnt + 4'd1;
            if (cnt == last) begin
                st <= (!io || (addr >= BASE && addr < BASE + 16'd8)) ? 2'd3 : 2'd0;
                if (ct == lhc_pkg::CT_IO_WR) mem[addr[2:0]] <= {nib[5], nib[4]};
                if (ct == lhc_pkg::CT_DMA_RD) mem[nib[0][2:0]] <= {nib[3], nib[2]};
            end
        end else if (st == 2'd3) begin
            lad_oe_o <= 1'b1;
            cnt <= cnt + 4'd1;
            if (cnt < waits) lad_o <= io ? lhc_pkg::SYNC_LONG : lhc_pkg::SYNC_SHORT;
            else if (cnt == waits) lad_o <= err_i ? lhc_pkg::SYNC_ERROR : lhc_pkg::SYNC_READY;
            else if (rd && cnt == waits + 4'd1) lad_o <= rbyte[3:0];
            else if (rd && cnt == waits + 4'd2) lad_o <= rbyte[7:4];
            else if (cnt <= waits + (rd ? 4'd3 : 4'd1)) lad_o <= lhc_pkg::TAR_NIB;
            else begin
                lad_oe_o <= 1'b0;
                st <= 2'd0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [15:0] BASE = 16'h03E8;
    logic              mclk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              req_valid_i = 1'b0;
    lhc_pkg::lhc_req_t req_i = '0;
    logic              sleep_i = 1'b0;
    logic              dma_want = 1'b0;
    logic              err_mode = 1'b0;
    logic              req_ready_o, rsp_valid_o, sleep_ready_o, dma_req_o, lclk_o;
    logic              lreset_n_o, lframe_n_o, lpcpd_n_o, lad_oe_o, dev_oe, ldrq_n;
    logic [3:0]        lad_o, dev_lad, lad_w;
    lhc_pkg::lhc_rsp_t rsp_o;
    logic [19:0]       exp_q [$];
    logic [19:0]       mon_e;
    logic [15:0]       a;
    logic [7:0]        d;
    int                err_total = 0;
    int                check_count = 0;
    int                seed = 3;

    always #10 mclk_i = ~mclk_i;
    // Released lines float high through the pull-ups
    assign lad_w = dev_oe ? dev_lad : (lad_oe_o ? lad_o : 4'hF);

    lhc_host #(.PD_LEAD_CYC(10), .RST_CLK_CYC(20)) u_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .sleep_i(sleep_i),
        .sleep_ready_o(sleep_ready_o), .dma_req_o(dma_req_o), .lclk_o(lclk_o),
        .lreset_n_o(lreset_n_o), .lframe_n_o(lframe_n_o), .lpcpd_n_o(lpcpd_n_o),
        .lad_o(lad_o), .lad_oe_o(lad_oe_o), .lad_i(lad_w), .ldrq_n_i(ldrq_n));
    lhc_dev_model #(.BASE(BASE)) u_dev (
        .mclk_i(mclk_i), .lclk_i(lclk_o), .lreset_n_i(lreset_n_o), .lframe_n_i(lframe_n_o),
        .lpcpd_n_i(lpcpd_n_o), .lad_i(lad_w), .dma_want_i(dma_want), .err_i(err_mode),
        .lad_o(dev_lad), .lad_oe_o(dev_oe), .ldrq_n_o(ldrq_n));

    // ****
    // Checking
    // ****
    task automatic check(input logic [9:0] seen, input logic [9:0] want);
        check_count++;
        if (seen !== want) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    always @(posedge mclk_i) begin
        if (rsp_valid_o === 1'b1) begin
            if (exp_q.size() == 0) err_total++;
            else begin
                mon_e = exp_q.pop_front();
                check(rsp_o & mon_e[19:10], mon_e[9:0]);
            end
        end
    end

    task automatic run(input lhc_pkg::lhc_kind_t k, input logic [15:0] ad, input logic [7:0] dt,
                       input logic [9:0] want, input logic [9:0] msk);
        int n;
        exp_q.push_back({msk, want});
        @(posedge mclk_i);
        req_i <= '{kind: k, addr: ad, chan: ad[2:0], data: dt};
        req_valid_i <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (lframe_n_o !== 1'b0 && n < 200);
        req_valid_i <= 1'b0;
        n = 0;
        while (exp_q.size() != 0 && n < 3000) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 3000) err_total++;
    endtask

    initial begin
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        check(10'({lframe_n_o, lad_oe_o}), 10'h002);
        repeat (30) @(posedge mclk_i);
        check(10'(lreset_n_o), 10'h001);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            a = BASE | 16'($random(seed) & 7);
            d = 8'($random(seed));
            run(lhc_pkg::LHC_IO_WR, a, d, 10'h000, 10'h003);
            run(lhc_pkg::LHC_IO_RD, a, 8'h00, {d, 2'b00}, 10'h3FF);
            run(lhc_pkg::LHC_DMA_RD, a, ~d, 10'h000, 10'h003);
            run(lhc_pkg::LHC_DMA_WR, a, 8'h00, {~d, 2'b00}, 10'h3FF);
        end
        $display("transfer test done");
        err_mode <= 1'b1;
        run(lhc_pkg::LHC_IO_RD, a, 8'h00, 10'h002, 10'h003);
        run(lhc_pkg::LHC_DMA_WR, a, 8'h00, 10'h002, 10'h003);
        err_mode <= 1'b0;
        run(lhc_pkg::LHC_IO_RD, a, 8'h00, {~d, 2'b00}, 10'h3FF);
        run(lhc_pkg::LHC_IO_RD, BASE + 16'h0100, 8'h00, 10'h003, 10'h003);
        $display("error test done");
        dma_want <= 1'b1;
        repeat (8) @(posedge mclk_i);
        check(10'(dma_req_o), 10'h001);
        sleep_i <= 1'b1;
        for (int n = 0; n < 200 && sleep_ready_o !== 1'b1; n++) @(posedge mclk_i);
        check(10'({sleep_ready_o, lpcpd_n_o, dma_req_o, req_ready_o}), 10'h008);
        dma_want <= 1'b0;
        sleep_i <= 1'b0;
        repeat (20) @(posedge mclk_i);
        check(10'({lpcpd_n_o, lreset_n_o, dma_req_o}), 10'h006);
        run(lhc_pkg::LHC_IO_WR, a, 8'h5A, 10'h000, 10'h003);
        run(lhc_pkg::LHC_IO_RD, a, 8'h00, {8'h5A, 2'b00}, 10'h3FF);
        $display("powerdown test done");
        print_verdict();
    end

    // Plan needs about 1k cycles; 50k means a hang
    initial begin
        #1_000_000;
        err_total++;
        print_verdict();
    end
endmodule
`default_nettype wire
